// *** core/sdh_channel.sv ***
`timescale 1ns/1ns
// How it works
// - first sensed closure drives the request line high at once
// - first sensed release returns the request line low at once
// - bounce edges on break never reach the request line; a bounce open on make counts as release
// - after release no new cycle until clean break interval has elapsed
// - without acknowledge the line follows the debounced switch state
// - seen acknowledge latches the line low though switch stays closed
// - after acknowledge, release watching and debouncing continue unchanged
// - a new closure is valid only after 20 ms of clean high input
// - line held low no later than 20 us after acknowledge
// - typical answer to acknowledge is just over one microsecond (ACK_CYCLES plus sync)
// - contact input reads high when open, low when closed
module sdh_channel
  import sdh_pkg::*;
#(
  parameter int unsigned CLEAN_CYC = CLEAN_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // switch contact, low while closed
  input wire logic switch_contact_input_in,
  // request_ack_line pin, three signals
  input wire logic request_ack_line_in,
  output logic request_ack_line_out,
  output logic request_ack_line_oe_out,
  // state visibility
  output logic request_pending_out
);
  sdh_state_type state;
  sdh_state_type next_state;
  logic sw_sync;
  logic line_sync;
  logic [CNT_W-1:0] clean_cnt;
  logic [CNT_W-1:0] next_clean_cnt;
  logic [CNT_W-1:0] ack_cnt;
  logic [CNT_W-1:0] next_ack_cnt;
  logic drive_high;
  logic [CNT_W-1:0] resp_cnt;

  // one counter step, shared by the acknowledge, clean and response timers
  function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] value);
    return value + CNT_ONE;
  endfunction : count_up

  sdh_sync u_sw_sync (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .async_in(switch_contact_input_in),
    .sync_out(sw_sync)
  );
  sdh_sync u_line_sync (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .async_in(request_ack_line_in),
    .sync_out(line_sync)
  );

  wire closed = !sw_sync;
  wire clean_done = (clean_cnt >= CLEAN_CYC[CNT_W-1:0]);
  // short glitches on the line are filtered; pulse must last ACK_CYCLES
  wire ack_seen = (ack_cnt >= ACK_CYCLES[CNT_W-1:0]);
  wire line_low = (state == SDH_ACTIVE) && !line_sync;

  always_comb begin
    next_state = state;
    next_clean_cnt = CNT_ZERO;
    next_ack_cnt = CNT_ZERO;
    case (state)
      SDH_IDLE: begin
        if (closed) begin
          next_state = SDH_ACTIVE;
        end
      end
      SDH_ACTIVE: begin
        if (!closed) begin
          next_state = SDH_BREAK;
        end else if (ack_seen) begin
          next_state = SDH_ACKED;
        end else if (line_low) begin
          next_ack_cnt = count_up(ack_cnt);
        end
      end
      SDH_ACKED: begin
        if (!closed) begin
          next_state = SDH_BREAK;
        end
      end
      SDH_BREAK: begin
        // any bounce back to closed restarts the clean window
        if (closed) begin
          next_clean_cnt = CNT_ZERO;
        end else if (clean_done) begin
          next_state = SDH_IDLE;
        end else begin
          next_clean_cnt = count_up(clean_cnt);
        end
      end
      default: begin
        next_state = SDH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= SDH_IDLE;
      clean_cnt <= CNT_ZERO;
      ack_cnt <= CNT_ZERO;
    end else begin
      state <= next_state;
      clean_cnt <= next_clean_cnt;
      ack_cnt <= next_ack_cnt;
    end
  end

  // line is driven at all times; high only while a request stands
  // host pulls low by overdriving, so the pad must be a weak or limited driver
  assign drive_high = (next_state == SDH_ACTIVE);
  assign request_ack_line_oe_out = 1'b1;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      request_ack_line_out <= 1'b0;
      request_pending_out <= 1'b0;
    end else begin
      request_ack_line_out <= drive_high;
      request_pending_out <= drive_high;
    end
  end

  a_make_raises: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_IDLE && closed) |=> request_ack_line_out)
    else $error("closure did not raise line");
  a_break_drops: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACTIVE && !closed) |=> !request_ack_line_out)
    else $error("release did not drop line");
  a_break_locks: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_BREAK && !clean_done) |=> !request_ack_line_out)
    else $error("new cycle before clean interval");
  a_clean_needed: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_BREAK && closed) |=> (clean_cnt == CNT_ZERO))
    else $error("bounce did not restart clean count");
  a_idle_low: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(request_ack_line_out) |-> $past(state) == SDH_IDLE)
    else $error("line rose outside idle");
  a_ack_latch: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACTIVE && closed && ack_seen) |=>
      (state == SDH_ACKED) ##0 !request_ack_line_out)
    else $error("acknowledge did not latch low");
  a_ack_limit: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACTIVE && closed && !line_sync) [*3] |-> ##[0:150]
      !request_ack_line_out)
    else $error("acknowledge not answered in time");
  a_acked_watch: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACKED && !closed) |=> (state == SDH_BREAK))
    else $error("release lost after acknowledge");
  a_follow_sw: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    request_ack_line_out |-> $past(closed))
    else $error("line high with switch open");

  // cycles the raised line has been seen pulled low; bounds the answer time
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      resp_cnt <= CNT_ZERO;
    end else if (line_low && request_ack_line_out) begin
      resp_cnt <= count_up(resp_cnt);
    end else begin
      resp_cnt <= CNT_ZERO;
    end
  end

  // counters, latch and mirror checks
  a_ack_in_time: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    resp_cnt <=
      ACK_LIMIT_CYCLES[CNT_W-1:0])
    else $error("line still high too long after acknowledge");
  a_ack_filter: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACTIVE && line_sync) |=>
      (ack_cnt == CNT_ZERO))
    else $error("high line did not clear acknowledge count");
  a_no_short_ack: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACTIVE && closed && !ack_seen) |=>
      (state != SDH_ACKED))
    else $error("acknowledge taken before pulse was long enough");
  a_acked_low: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACKED) |->
      !request_ack_line_out)
    else $error("line not latched low after acknowledge");
  a_acked_holds: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACKED && closed) |=>
      (state == SDH_ACKED))
    else $error("acknowledged cycle left while switch closed");
  a_pending_same: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    request_pending_out ==
      request_ack_line_out)
    else $error("pending flag differs from line");
  a_line_active: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_ACTIVE) |->
      request_ack_line_out)
    else $error("line low during a standing request");
  a_idle_out_low: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_IDLE) |->
      !request_ack_line_out)
    else $error("line high while idle");
  a_clean_step: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_BREAK && !closed && !clean_done) |=>
      (clean_cnt == $past(clean_cnt) + CNT_ONE))
    else $error("clean count did not advance");
  a_clean_exit: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == SDH_BREAK && !closed && clean_done) |=>
      (state == SDH_IDLE))
    else $error("clean interval did not rearm");
  a_rise_needs_close: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(request_ack_line_out) |->
      $past(!sw_sync))
    else $error("line rose without low contact input");
endmodule : sdh_channel

// *** core/sdh_pkg.sv ***
package sdh_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // clean release time, milliseconds
  localparam int unsigned CLEAN_TIME_MS = 20;
  localparam int unsigned CLEAN_CYCLES = (CLEAN_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // acknowledge pulse must be seen this long, ns (host pulse nominal 5 us)
  localparam int unsigned ACK_MIN_NS = 1000;
  localparam int unsigned ACK_CYCLES = (ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // latest termination after acknowledge, microseconds
  localparam int unsigned ACK_LIMIT_US = 20;
  localparam int unsigned ACK_LIMIT_CYCLES = (ACK_LIMIT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 22;
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h00_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 22'h00_0001;
  typedef enum logic [1:0] {
    SDH_IDLE = 2'b00,
    SDH_ACTIVE = 2'b01,
    SDH_ACKED = 2'b10,
    SDH_BREAK = 2'b11
  } sdh_state_type;
endpackage : sdh_pkg

// *** core/sdh_sync.sv ***
`timescale 1ns/1ns
module sdh_sync
  import sdh_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // pin level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  // reset high: the contact input idles high through its pull-up
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage1 <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : sdh_sync

// *** testbench/sdh_host_model.sv ***
`timescale 1ns/1ns
module sdh_host_model (
  // clock
  input wire logic clk_sys_in,
  // host side
  input wire logic enable_in,
  input wire logic line_in,
  output logic pull_low_out
);
  int unsigned cnt = 0;
  initial pull_low_out = 1'h0;
  // pin is input while idle; only a high level is a request
  always @(posedge clk_sys_in) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
      pull_low_out <= (cnt > 1);
    end else if (enable_in && line_in === 1'h1 && !pull_low_out) begin
      pull_low_out <= 1'h1;
      cnt <= 500;
    end
  end
endmodule : sdh_host_model

// *** testbench/switch_debounce_handshake_tb.sv ***
`timescale 1ns/1ns
module switch_debounce_handshake_tb;
  import sdh_pkg::*;
  localparam int unsigned CC = 50;
  logic clk_sys_in, arst_n_in, sw, host_en, line_out, line_oe, pending;
  wire logic host_low;
  // host wins the wired line
  wire logic line = host_low ? 1'h0 : line_out;
  int num_errors = 0;
  int n_compared = 0;
  logic [31:0] rng = 32'h0000_6490;
  sdh_channel #(.CLEAN_CYC(CC)) u_sdh_channel (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .switch_contact_input_in(sw), .request_ack_line_in(line),
    .request_ack_line_out(line_out), .request_ack_line_oe_out(line_oe),
    .request_pending_out(pending));
  sdh_host_model u_sdh_host_model (.clk_sys_in(clk_sys_in), .enable_in(host_en),
    .line_in(line), .pull_low_out(host_low));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic want(input logic closed, input logic acked);
    return closed && !acked;
  endfunction : want
  task automatic check(input string nm, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc
  task automatic end_sim;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk_sys_in = 1'h0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // a run takes under 3000 cycles; 10000 means a hang
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    sw = 1'h1;
    host_en = 1'h0;
    arst_n_in = 1'h0;
    cyc(16);
    arst_n_in = 1'h1;
    check("oe", line_oe, 1'h1);
    for (int a = 0; a < 2; a++) begin
      host_en = a[0];
      cyc(2);
      sw = 1'h0;
      cyc(3);
      check("line", line, 1'h1);
      cyc(600);
      check("line", line, want(1'h1, a[0]));
      check("pending", pending, want(1'h1, a[0]));
      sw = 1'h1;
      cyc(3);
      check("line", line, 1'h0);
      // random break bounce must never reach the line
      repeat (20) begin
        rng = xs(rng);
        // no two open spans in a row, so no span reaches the clean time
        sw = rng[0] & ~sw;
        cyc(1 + int'(rng[3:1]));
        check("line", line, 1'h0);
      end
      sw = 1'h0;
      cyc(2);
      sw = 1'h1;
      cyc(CC - 5);
      sw = 1'h0;
      cyc(5);
      check("line", line, 1'h0);
      sw = 1'h1;
      cyc(CC + 10);
      sw = 1'h0;
      cyc(3);
      check("line", line, 1'h1);
      sw = 1'h1;
      cyc(CC + 10);
    end
    cyc(600);
    // reset in mid-run under a standing request; the request must come back
    host_en = 1'h0;
    sw = 1'h0;
    cyc(3);
    check("line", line, 1'h1);
    arst_n_in = 1'h0;
    cyc(2);
    arst_n_in = 1'h1;
    cyc(3);
    check("line", line, 1'h1);
    check("pending", pending, 1'h1);
    sw = 1'h1;
    cyc(CC + 10);
    end_sim();
  end
endmodule : switch_debounce_handshake_tb
